// ---- rtl/lioac_pkg.sv ----
// Shared constants and types of the logic input/output action controller
package lioac_pkg;

	// Pin counts and action store shape
	localparam int N_IN = 24;
	localparam int N_OUT = 20;
	localparam int N_GVAL = 16;
	localparam int N_SLOT = 88;
	localparam int SLOT_W = 7;
	localparam int CODE_W = 8;

	// Slot bases: activate, deactivate, held repeat, then group values
	localparam logic [6:0] SLOT_ACT = 7'h00;
	localparam logic [6:0] SLOT_DEACT = 7'h18;
	localparam logic [6:0] SLOT_HELD = 7'h30;
	localparam logic [6:0] SLOT_GRP = 7'h48;
	localparam int N_PIN_SLOT = 72;

	// Register byte offsets
	localparam logic [7:0] REG_CLEAR = 8'h00;
	localparam logic [7:0] REG_IN_MASK = 8'h04;
	localparam logic [7:0] REG_IN_POL = 8'h08;
	localparam logic [7:0] REG_GROUP = 8'h0C;
	localparam logic [7:0] REG_OUT_STATE = 8'h10;
	localparam logic [7:0] REG_OUT_COND = 8'h14;
	localparam logic [7:0] REG_ACTION = 8'h18;
	localparam logic [7:0] REG_IN_STATE = 8'h1C;
	localparam logic [7:0] REG_IRQ_STS = 8'h20;
	localparam logic [7:0] REG_IRQ_MSK = 8'h24;

	// Field positions
	localparam int CLR_PIN_LSB = 0;
	localparam int CLR_ALL_BIT = 8;
	localparam int ACT_CODE_LSB = 0;
	localparam int ACT_SLOT_LSB = 8;
	localparam int ACT_ASSIGN_BIT = 16;
	localparam int IRQ_ACTION = 0;
	localparam int IRQ_INPUT = 1;
	localparam int IRQ_NVDONE = 2;
	localparam int IRQ_W = 3;

	// Reset values
	localparam logic [23:0] MASK_RST = 24'hFFFFFF;
	localparam logic [23:0] POL_RST = 24'h000000;
	localparam logic [2:0] IRQ_MSK_RST = 3'h0;

	// Timing: clock rate, non-volatile write time, held repeat period
	localparam int CLK_MHZ = 200;
	localparam int NV_WRITE_US = 5000;
	localparam int NV_WRITE_CYC = NV_WRITE_US * CLK_MHZ;
	localparam int HELD_REPEAT_MS = 100;
	localparam int HELD_CYC = HELD_REPEAT_MS * 1000 * CLK_MHZ;

	// One issued action: which slot fired and its stored code
	typedef struct packed
	{
		logic [6:0] slot;
		logic [7:0] code;
	} lioac_act_t;

	typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_EMIT} lioac_state_t;

endpackage

// ---- rtl/lioac_act_mem.sv ----
// Action code store, one write port and one registered read port
module lioac_act_mem #(
	parameter int DEPTH = 88,
	parameter int AW = 7,
	parameter int DW = 8
) (
	input wire logic clk_sys, // System clock
	input wire logic ce, // Clock enable
	input wire logic we, // Write strobe
	input wire logic [AW-1:0] waddr, // Write slot
	input wire logic [DW-1:0] wdata, // Write code
	input wire logic [AW-1:0] raddr, // Read slot
	output logic [DW-1:0] rdata_ff // Registered read code
);
	logic [DW-1:0] mem [DEPTH];

	// Contents carry no reset; validity is tracked by the caller
	always_ff @(posedge clk_sys)
	begin
		if (ce && we)
			mem[waddr] <= wdata;
	end

	// Registered read keeps the lookup off the arbiter path
	always_ff @(posedge clk_sys)
	begin
		if (ce)
			rdata_ff <= mem[raddr];
	end
endmodule

// ---- rtl/lioac_nv_timer.sv ----
// Busy timer standing for one non-volatile write
module lioac_nv_timer #(
	parameter int NV_CYC = 1000000
) (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Asynchronous reset
	input wire logic ce, // Clock enable
	input wire logic start, // Begin a write
	output logic busy_ff, // Write in progress
	output logic done_ff // One cycle at write end
);
	logic [31:0] cnt_ff;

	// Count down the write time; a start while busy is ignored
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cnt_ff <= 32'h0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else if (ce)
		begin
			done_ff <= 1'b0;
			if (start && !busy_ff)
			begin
				cnt_ff <= 32'(NV_CYC);
				busy_ff <= 1'b1;
			end
			else if (busy_ff)
			begin
				if (cnt_ff <= 32'h1)
				begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
				cnt_ff <= cnt_ff - 32'h1;
			end
		end
	end
endmodule

// ---- rtl/lioac_top.sv ----
// Logic input/output action controller with Wishbone register access
module lioac_top #(
	parameter int NV_CYC = lioac_pkg::NV_WRITE_CYC,
	parameter int HELD_PERIOD = lioac_pkg::HELD_CYC
) (
	input wire logic clk_sys, // System clock, 200 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [3:0] wb_sel_i, // Wishbone byte enables
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic [lioac_pkg::N_IN-1:0] logic_in, // Logic input pins
	input wire logic por_preset_load, // Power-on preset holds a mask
	input wire logic [lioac_pkg::N_IN-1:0] por_preset_mask, // Mask of that preset
	input wire logic [lioac_pkg::N_OUT-1:0] cond_state, // Output condition results
	output logic [lioac_pkg::N_OUT-1:0] logic_out, // Logic output pins
	output logic act_valid, // Action ready to run
	input wire logic act_ready, // Action taken by the runner
	output lioac_pkg::lioac_act_t act, // Slot and code of the action
	output logic irq // Level interrupt
);
	import lioac_pkg::*;

	logic started_ff, ack_ff, wait_ff, nv_done;
	logic [31:0] rdat_ff, rd_mux;
	logic [N_IN-1:0] mask_ff, mask_prev_ff, pol_ff, grp_ff, prev_act_ff, snap_ff;
	logic [N_IN-1:0] act_now, reen, rise_ev, fall_ev, held_set;
	logic [N_OUT-1:0] out_dir_ff, cond_en_ff, logic_out_ff;
	logic [N_SLOT-1:0] vld_ff, nxt_vld;
	logic [N_PIN_SLOT-1:0] pend_ff, nxt_pend, pend_set, pend_clr;
	logic [IRQ_W-1:0] sts_ff, msk_ff, sts_set;
	logic [23:0] pat, pat_prev_ff;
	logic [3:0] grp_val_ff;
	logic grp_pend_ff, held_tick, accept, wr, nv_reg, issue_grp, issue_pin;
	logic [31:0] held_cnt_ff;
	logic [6:0] rd_slot, slot_ff, pick;
	logic [7:0] mem_rdata;
	lioac_state_t state_ff;
	lioac_act_t act_ff;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction

	// Group pattern, lowest-numbered member lands in the MSB
	function automatic logic [23:0] pattern(input logic [23:0] a, input logic [23:0] m);
		logic [23:0] v;
		v = 24'h0;
		for (int i = 0; i < N_IN; i++)
			if (m[i])
				v = {v[22:0], a[i]};
		return v;
	endfunction

	// Lowest pending pin slot
	function automatic logic [6:0] first_set(input logic [71:0] v);
		logic [6:0] r;
		r = 7'h0;
		for (int i = N_PIN_SLOT - 1; i >= 0; i--)
			if (v[i])
				r = 7'(i);
		return r;
	endfunction

	// Bus decode: a request is taken once, then waits for its answer
	assign accept = wb_cyc_i && wb_stb_i && !ack_ff && !wait_ff;
	assign wr = accept && wb_we_i;
	assign nv_reg = (wb_adr_i == REG_CLEAR) || (wb_adr_i == REG_IN_POL) ||
		(wb_adr_i == REG_GROUP) || (wb_adr_i == REG_OUT_COND) || (wb_adr_i == REG_ACTION);
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	lioac_nv_timer #(.NV_CYC(NV_CYC)) u_nv (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.start(wr && nv_reg),
		.busy_ff(),
		.done_ff(nv_done)
	);

	// Stored settings hold the answer until the write finishes
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ack_ff <= 1'b0;
			wait_ff <= 1'b0;
			rdat_ff <= 32'h0;
		end
		else if (ce)
		begin
			ack_ff <= 1'b0;
			if (wr && nv_reg)
				wait_ff <= 1'b1;
			else if (accept)
			begin
				ack_ff <= 1'b1;
				rdat_ff <= wb_we_i ? 32'h0 : rd_mux;
			end
			if (wait_ff && nv_done)
			begin
				wait_ff <= 1'b0;
				ack_ff <= 1'b1;
			end
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rd_mux = 32'h0;
		case (wb_adr_i)
			REG_IN_MASK: rd_mux = {8'h0, mask_ff};
			REG_IN_POL: rd_mux = {8'h0, pol_ff};
			REG_GROUP: rd_mux = {8'h0, grp_ff};
			REG_OUT_STATE: rd_mux = {12'h0, logic_out_ff};
			REG_OUT_COND: rd_mux = {12'h0, cond_en_ff};
			REG_IN_STATE: rd_mux = {8'h0, act_now};
			REG_IRQ_STS: rd_mux = {29'h0, sts_ff};
			REG_IRQ_MSK: rd_mux = {29'h0, msk_ff};
			default: rd_mux = 32'h0;
		endcase
	end

	// Mask, polarity and group; the mask comes from the power-on preset when por_preset_load is high in the first cycle after reset
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			started_ff <= 1'b0;
			mask_ff <= MASK_RST;
			pol_ff <= POL_RST;
			grp_ff <= 24'h0;
		end
		else if (ce)
		begin
			started_ff <= 1'b1;
			if (!started_ff && por_preset_load)
				mask_ff <= por_preset_mask;
			else if (wr && wb_adr_i == REG_IN_MASK)
				mask_ff <= 24'(merge({8'h0, mask_ff}, wb_dat_i, wb_sel_i));
			if (wr && wb_adr_i == REG_IN_POL)
				pol_ff <= 24'(merge({8'h0, pol_ff}, wb_dat_i, wb_sel_i));
			if (wr && wb_adr_i == REG_GROUP)
				grp_ff <= 24'(merge({8'h0, grp_ff}, wb_dat_i, wb_sel_i));
		end
	end

	// Active sense: low pin is active unless inverted
	assign act_now = ~logic_in ^ pol_ff;

	// Edge detection, honouring mask and re-enable difference
	assign reen = mask_ff & ~mask_prev_ff;
	assign rise_ev = {N_IN{started_ff}} & ((mask_ff & mask_prev_ff & act_now & ~prev_act_ff) |
		(reen & act_now & ~snap_ff));
	assign fall_ev = {N_IN{started_ff}} & ((mask_ff & mask_prev_ff & ~act_now & prev_act_ff) |
		(reen & ~act_now & snap_ff));
	assign held_set = {N_IN{held_tick}} & mask_ff & act_now;

	// History of inputs; snapshot taken when a pin is masked off
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			prev_act_ff <= 24'h0;
			mask_prev_ff <= MASK_RST;
			snap_ff <= 24'h0;
		end
		else if (ce)
		begin
			prev_act_ff <= act_now;
			mask_prev_ff <= started_ff ? mask_ff : 24'hFFFFFF;
			for (int i = 0; i < N_IN; i++)
				if (mask_prev_ff[i] && !mask_ff[i])
					snap_ff[i] <= prev_act_ff[i];
		end
	end

	// Held repeat tick
	assign held_tick = (held_cnt_ff == 32'h0);
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			held_cnt_ff <= 32'h0;
		else if (ce)
			held_cnt_ff <= held_tick ? 32'(HELD_PERIOD - 1) : held_cnt_ff - 32'h1;
	end

	// Action validity: assign, remove, clear one pin or all pins
	always_comb
	begin
		nxt_vld = vld_ff;
		if (wr && wb_adr_i == REG_ACTION && 32'(wb_dat_i[ACT_SLOT_LSB +: SLOT_W]) < N_SLOT)
			nxt_vld[wb_dat_i[ACT_SLOT_LSB +: SLOT_W]] = wb_dat_i[ACT_ASSIGN_BIT];
		if (wr && wb_adr_i == REG_CLEAR)
		begin
			if (wb_dat_i[CLR_ALL_BIT])
				nxt_vld[N_PIN_SLOT-1:0] = '0;
			else if (wb_dat_i[CLR_PIN_LSB +: 5] < 5'(N_IN))
			begin
				nxt_vld[SLOT_ACT + 7'(wb_dat_i[CLR_PIN_LSB +: 5])] = 1'b0;
				nxt_vld[SLOT_DEACT + 7'(wb_dat_i[CLR_PIN_LSB +: 5])] = 1'b0;
				nxt_vld[SLOT_HELD + 7'(wb_dat_i[CLR_PIN_LSB +: 5])] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			vld_ff <= '0;
		else if (ce)
			vld_ff <= nxt_vld;
	end

	lioac_act_mem #(.DEPTH(N_SLOT), .AW(SLOT_W), .DW(CODE_W)) u_mem (
		.clk_sys(clk_sys),
		.ce(ce),
		.we(wr && wb_adr_i == REG_ACTION && wb_dat_i[ACT_ASSIGN_BIT]),
		.waddr(wb_dat_i[ACT_SLOT_LSB +: SLOT_W]),
		.wdata(wb_dat_i[ACT_CODE_LSB +: CODE_W]),
		.raddr(rd_slot),
		.rdata_ff(mem_rdata)
	);

	// Pending actions: a new event wins over the issue clear
	assign pend_set = {held_set, fall_ev, rise_ev} &
		vld_ff[N_PIN_SLOT-1:0];
	assign issue_grp = (state_ff == ST_IDLE) && grp_pend_ff;
	assign issue_pin = (state_ff == ST_IDLE) && !grp_pend_ff && (|pend_ff);
	assign pick = first_set(pend_ff);
	always_comb
	begin
		pend_clr = '0;
		if (issue_pin)
			pend_clr[pick] = 1'b1;
		nxt_pend = ((pend_ff & ~pend_clr) | pend_set) & vld_ff[N_PIN_SLOT-1:0];
	end
	assign rd_slot = issue_grp ? SLOT_GRP + 7'(grp_val_ff) : pick;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			pend_ff <= '0;
		else if (ce)
			pend_ff <= nxt_pend;
	end

	// Group pattern watcher; values past the store are ignored
	assign pat = pattern(act_now, grp_ff);
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pat_prev_ff <= 24'h0;
			grp_pend_ff <= 1'b0;
			grp_val_ff <= 4'h0;
		end
		else if (ce)
		begin
			pat_prev_ff <= pat;
			if (started_ff && pat != pat_prev_ff && (|grp_ff) && pat < 24'(N_GVAL) &&
				vld_ff[SLOT_GRP + 7'(pat[3:0])])
			begin
				grp_pend_ff <= 1'b1;
				grp_val_ff <= pat[3:0];
			end
			else if (issue_grp)
				grp_pend_ff <= 1'b0;
		end
	end

	// Issue sequencer: pick, look up the code, offer it
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= ST_IDLE;
			slot_ff <= 7'h0;
			act_ff <= '0;
		end
		else if (ce)
		begin
			case (state_ff)
				ST_IDLE:
					if (issue_grp || issue_pin)
					begin
						slot_ff <= rd_slot;
						state_ff <= ST_LOOK;
					end
				ST_LOOK:
				begin
					act_ff <= '{slot: slot_ff, code: mem_rdata};
					state_ff <= ST_EMIT;
				end
				ST_EMIT:
					if (act_ready)
						state_ff <= ST_IDLE;
				default: state_ff <= ST_IDLE;
			endcase
		end
	end
	assign act_valid = (state_ff == ST_EMIT);
	assign act = act_ff;

	// Outputs: conditions override direct writes, mask does not block them
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			out_dir_ff <= 20'h0;
			cond_en_ff <= 20'h0;
			logic_out_ff <= 20'h0;
		end
		else if (ce)
		begin
			if (wr && wb_adr_i == REG_OUT_STATE)
				out_dir_ff <= 20'(merge({12'h0, out_dir_ff}, wb_dat_i, wb_sel_i));
			if (wr && wb_adr_i == REG_OUT_COND)
				cond_en_ff <= 20'(merge({12'h0, cond_en_ff}, wb_dat_i, wb_sel_i));
			logic_out_ff <= (cond_en_ff & cond_state) | (~cond_en_ff & out_dir_ff);
		end
	end
	assign logic_out = logic_out_ff;

	// Interrupt status, write one to clear; a new event wins
	assign sts_set = {nv_done, |(rise_ev | fall_ev), act_valid && act_ready};
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sts_ff <= 3'h0;
			msk_ff <= IRQ_MSK_RST;
		end
		else if (ce)
		begin
			if (wr && wb_adr_i == REG_IRQ_STS)
				sts_ff <= (sts_ff & ~wb_dat_i[IRQ_W-1:0]) | sts_set;
			else
				sts_ff <= sts_ff | sts_set;
			if (wr && wb_adr_i == REG_IRQ_MSK)
				msk_ff <= wb_dat_i[IRQ_W-1:0];
		end
	end
	assign irq = |(sts_ff & msk_ff);

	// Checks on the design's own outputs and internal state
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst || !ce);

	chk_clear_one_pin: assert property (wr && wb_adr_i == REG_CLEAR
		&& !wb_dat_i[CLR_ALL_BIT] && wb_dat_i[4:0] < 5'(N_IN) |=> !vld_ff[$past(wb_dat_i[4:0])])
		else $error("pin clear left an action");
	chk_clear_all_pins: assert property (wr && wb_adr_i == REG_CLEAR
		&& wb_dat_i[CLR_ALL_BIT] |=> vld_ff[N_PIN_SLOT-1:0] == '0 && pend_ff == '0)
		else $error("wildcard clear left actions");
	chk_mask_read: assert property (accept && !wb_we_i && wb_adr_i == REG_IN_MASK
		|=> wb_ack_o && wb_dat_o == {8'h0, $past(mask_ff)})
		else $error("mask read wrong");
	chk_masked_quiet: assert property (mask_ff != MASK_RST
		|-> ((rise_ev | fall_ev | held_set) & ~mask_ff) == '0)
		else $error("masked input produced an event");
	chk_reenable_once: assert property (started_ff && (|reen)
		|-> ((rise_ev | fall_ev) & reen) == (reen & (act_now ^ snap_ff)))
		else $error("re-enable transition missed");
	chk_nv_ack_late: assert property (wr && nv_reg |-> !wb_ack_o [*2] ##0 wait_ff)
		else $error("stored write answered early");
	chk_out_override: assert property (cond_en_ff[0]
		|=> logic_out[0] == $past(cond_state[0]))
		else $error("condition did not drive output");
	chk_out_direct: assert property (!cond_en_ff[0] && wr && wb_adr_i == REG_OUT_STATE
		&& wb_sel_i[0] |=> ##1 logic_out[0] == $past(wb_dat_i[0], 2))
		else $error("direct write not seen on output");
	chk_group_value: assert property (grp_ff == 24'h42
		|-> pat == {22'h0, act_now[1], act_now[6]})
		else $error("group value order wrong");
	chk_emit_hold: assert property (act_valid && !act_ready |=> act_valid && $stable(act))
		else $error("action offer dropped");

	cov_action_taken: cover property (act_valid && act_ready);
	cov_group_fire: cover property (issue_grp);
	cov_reenable: cover property (|reen ##1 |pend_ff);
	cov_nv_ack: cover property (wait_ff && nv_done);
endmodule

// ---- sim/lioac_runner.sv ----
// Action runner model that takes offered actions, alternately prompt and stalling
module lioac_runner (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Asynchronous reset
	input wire logic act_valid, // Action offered
	input wire lioac_pkg::lioac_act_t act, // Offered slot and code
	output logic act_ready, // Take strobe
	output lioac_pkg::lioac_act_t last_ff, // Last action taken
	output int n_taken_ff // Number of actions taken
);
	timeunit 1ns;
	timeprecision 100ps;
	import lioac_pkg::*;
	logic [1:0] stall_ff;

	// Ready waits out a stall; every other take stalls three cycles to test slow runners
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			act_ready <= 1'b0;
			stall_ff <= 2'h0;
			last_ff <= '0;
			n_taken_ff <= 0;
		end
		else if (act_valid && act_ready)
		begin
			act_ready <= 1'b0;
			last_ff <= act;
			n_taken_ff <= n_taken_ff + 1;
			stall_ff <= n_taken_ff[0] ? 2'h0 : 2'h3;
		end
		else if (act_valid && stall_ff == 2'h0)
			act_ready <= 1'b1;
		else if (act_valid)
			stall_ff <= stall_ff - 2'h1;
	end
endmodule

// ---- sim/lioac_bench.sv ----
// Self-checking bench for the logic input/output action controller
module lioac_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import lioac_pkg::*;
	localparam int NVC = 8;
	logic clk_sys, rst, ce, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, por_preset_load;
	logic act_valid, act_ready, irq;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0] wb_sel_i;
	logic [23:0] logic_in, por_preset_mask;
	logic [19:0] cond_state, logic_out;
	lioac_act_t act, last;
	int n_taken, n_fail, checked, wait_n, n_exp;

	lioac_top #(.NV_CYC(NVC), .HELD_PERIOD(16)) dut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
		.wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
		.logic_in(logic_in), .por_preset_load(por_preset_load),
		.por_preset_mask(por_preset_mask), .cond_state(cond_state), .logic_out(logic_out),
		.act_valid(act_valid), .act_ready(act_ready), .act(act), .irq(irq));
	lioac_runner u_run (.clk_sys(clk_sys), .rst(rst), .act_valid(act_valid), .act(act),
		.act_ready(act_ready), .last_ff(last), .n_taken_ff(n_taken));

	// Free-running 200 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One classic cycle; the request stands until ack is sampled, then idles a cycle
	task automatic wb_io(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		wait_n = 0;
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= d;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			wait_n++;
		end
		while (wb_ack_o !== 1'b1 && wait_n < 200);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wait_n >= 200)
		begin
			n_fail++;
			report_and_stop();
		end
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_io(a, 1'b1, d, q);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb_io(a, 1'b0, 32'h0, q);
		chk(q, exp);
	endtask

	// Waits until the runner has taken the next expected action and compares it;
	// counting expected actions catches one already taken during a long stored write
	task automatic wait_act(input logic [6:0] s, input logic [7:0] c);
		int k;
		k = 0;
		n_exp++;
		while (n_taken < n_exp && k < 300)
		begin
			@(posedge clk_sys);
			k++;
		end
		if (k >= 300)
		begin
			n_fail++;
			report_and_stop();
		end
		chk({17'h0, last}, {17'h0, s, c});
	endtask

	// No action beyond those expected so far may be taken
	task automatic no_act(input int cyc);
		repeat (cyc) @(posedge clk_sys);
		chk(n_taken, n_exp);
	endtask

	function automatic logic [31:0] aw(input logic [6:0] s, input logic [7:0] c);
		return {15'h0, 1'b1, 1'b0, s, c};
	endfunction

	// Main sequence; idle pins sit high, which is inactive under normal polarity
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		{wb_we_i, wb_cyc_i, wb_stb_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hF;
		logic_in = 24'hFFFFFF;
		por_preset_load = 1'b0;
		por_preset_mask = 24'h00F0F0;
		cond_state = 20'h00000;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rdc(REG_IN_MASK, 32'h00FFFFFF);
		rdc(REG_IN_POL, 32'h0);
		rdc(8'h3C, 32'h0);
		$display("test reset done");
		wr(REG_ACTION, aw(SLOT_ACT + 7'h03, 8'h5A));
		chk({31'h0, wait_n > NVC}, 32'h1);
		wr(REG_ACTION, aw(SLOT_DEACT + 7'h03, 8'h6B));
		logic_in[3] <= 1'b0;
		wait_act(SLOT_ACT + 7'h03, 8'h5A);
		logic_in[3] <= 1'b1;
		wait_act(SLOT_DEACT + 7'h03, 8'h6B);
		wr(REG_IN_POL, 32'h8);
		chk({31'h0, wait_n > NVC}, 32'h1);
		wait_act(SLOT_ACT + 7'h03, 8'h5A);
		rdc(REG_IN_POL, 32'h8);
		rdc(REG_IN_STATE, 32'h8);
		wr(REG_IN_POL, 32'h0);
		wait_act(SLOT_DEACT + 7'h03, 8'h6B);
		$display("test edges and polarity done");
		wr(REG_IN_MASK, 32'h00FFFFF7);
		rdc(REG_IN_MASK, 32'h00FFFFF7);
		logic_in[3] <= 1'b0;
		repeat (3) @(posedge clk_sys);
		logic_in[3] <= 1'b1;
		repeat (3) @(posedge clk_sys);
		logic_in[3] <= 1'b0;
		no_act(20);
		wr(REG_IN_MASK, 32'h00FFFFFF);
		wait_act(SLOT_ACT + 7'h03, 8'h5A);
		no_act(20);
		logic_in[3] <= 1'b1;
		wait_act(SLOT_DEACT + 7'h03, 8'h6B);
		$display("test mask done");
		wr(REG_ACTION, aw(SLOT_HELD + 7'h03, 8'h7C));
		logic_in[3] <= 1'b0;
		wait_act(SLOT_ACT + 7'h03, 8'h5A);
		wait_act(SLOT_HELD + 7'h03, 8'h7C);
		wait_act(SLOT_HELD + 7'h03, 8'h7C);
		logic_in[3] <= 1'b1;
		wait_act(SLOT_DEACT + 7'h03, 8'h6B);
		wr(REG_CLEAR, 32'h3);
		logic_in[3] <= 1'b0;
		no_act(40);
		logic_in[3] <= 1'b1;
		no_act(20);
		wr(REG_ACTION, aw(SLOT_ACT + 7'h05, 8'h11));
		wr(REG_ACTION, aw(SLOT_DEACT + 7'h09, 8'h22));
		wr(REG_CLEAR, 32'h100);
		logic_in <= 24'hFFFDDF;
		no_act(20);
		logic_in <= 24'hFFFFFF;
		no_act(20);
		$display("test clear done");
		wr(REG_GROUP, 32'h42);
		wr(REG_ACTION, aw(SLOT_GRP + 7'h02, 8'h9D));
		logic_in[1] <= 1'b0;
		wait_act(SLOT_GRP + 7'h02, 8'h9D);
		logic_in[1] <= 1'b1;
		no_act(20);
		rdc(REG_GROUP, 32'h42);
		ce <= 1'b0;
		logic_in[1] <= 1'b0;
		no_act(10);
		ce <= 1'b1;
		wait_act(SLOT_GRP + 7'h02, 8'h9D);
		logic_in[1] <= 1'b1;
		$display("test group done");
		wr(REG_OUT_STATE, 32'h000A5A5A);
		@(posedge clk_sys);
		chk({12'h0, logic_out}, 32'h000A5A5A);
		rdc(REG_OUT_STATE, 32'h000A5A5A);
		cond_state <= 20'h00005;
		wr(REG_OUT_COND, 32'h0000F);
		@(posedge clk_sys);
		chk({12'h0, logic_out}, 32'h000A5A55);
		rdc(REG_OUT_COND, 32'h0000000F);
		wr(REG_OUT_STATE, 32'h0);
		@(posedge clk_sys);
		rdc(REG_OUT_STATE, 32'h00000005);
		$display("test outputs done");
		rdc(REG_IRQ_STS, 32'h7);
		chk({31'h0, irq}, 32'h0);
		wr(REG_IRQ_MSK, 32'h2);
		rdc(REG_IRQ_MSK, 32'h2);
		chk({31'h0, irq}, 32'h1);
		wr(REG_IRQ_STS, 32'h2);
		chk({31'h0, irq}, 32'h0);
		rdc(REG_IRQ_STS, 32'h5);
		$display("test interrupt done");
		rst <= 1'b1;
		por_preset_load <= 1'b1;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rdc(REG_IN_MASK, 32'h0000F0F0);
		rdc(REG_IN_POL, 32'h0);
		$display("test preset done");
		report_and_stop();
	end
endmodule
